// [rtl/csm_pkg.sv]
// Package for the processor status and mode register block
package csm_pkg;

    localparam int CSM_AW = 8;
    localparam int CSM_DW = 32;

    // Register byte offsets
    localparam logic [CSM_AW-1:0] STATUS_OFS = 8'h00;
    localparam logic [CSM_AW-1:0] VIEW_OFS   = 8'h04;

    // Reset value: error level and boot vector select set
    localparam logic [CSM_DW-1:0] STATUS_RESET = 32'h0040_0004;
    // Writable bits; reserved positions 27, 24, 23, 21, 19 stay zero
    localparam logic [CSM_DW-1:0] STATUS_WMASK = 32'hf657_ffff;

    // Cycles from the write edge until a set interrupt enable acts
    localparam int IRQ_EN_SET_DELAY = 3;

    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] PRIV_SUPER  = 2'h1;
    localparam logic [1:0] PRIV_USER   = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_KERNEL,
        MODE_SUPER,
        MODE_USER
    } csm_mode_t;

    typedef struct packed {
        logic [3:0] coprocUsableBits;
        logic       rsv27;
        logic       fpuRegisterCountSelect;
        logic       byteOrderFlipUser;
        logic [1:0] rsv24;
        logic       bootVectorSelect;
        logic       rsv21;
        logic       warmResetIndicator;
        logic       rsv19;
        logic       lastProbeHitFlag;
        logic       checkBitOverride;
        logic       parityExceptionDisable;
        logic [7:0] interruptMaskBits;
        logic       kernelExtendedVectorSelect;
        logic       supervisorWideAddressing;
        logic       userWideAddressing;
        logic [1:0] privilegeModeField;
        logic       errorLevelFlag;
        logic       exceptionLevelFlag;
        logic       globalIrqEnable;
    } csm_status_t;

    typedef struct packed {
        logic [7:0] rsv;
        logic [7:0] pendingRaw;
        logic [7:0] pendingMasked;
        logic [3:0] cpUsable;
        logic       irqTake;
        logic       irqEnabled;
        csm_mode_t  mode;
    } csm_view_t;

    typedef struct packed {
        logic [CSM_AW-1:0] awaddr;
        logic              awvalid;
        logic [CSM_DW-1:0] wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [CSM_AW-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } csm_axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic [1:0]        bresp;
        logic              bvalid;
        logic              arready;
        logic [CSM_DW-1:0] rdata;
        logic [1:0]        rresp;
        logic              rvalid;
    } csm_axil_rsp_t;

endpackage

// [rtl/csm_axil_port.sv]
// AXI4-Lite slave front end for the status register block
`timescale 1ns/1ps
module csm_axil_port import csm_pkg::*; (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire csm_axil_req_t       axiReq,
    output csm_axil_rsp_t            axiRsp,
    output logic                     wrFire,
    output logic [CSM_AW-1:0]        wrAddr,
    output logic [CSM_DW-1:0]        wrData,
    output logic [3:0]               wrStrb,
    input  wire logic                wrHit,
    output logic [CSM_AW-1:0]        rdAddr,
    input  wire logic [CSM_DW-1:0]   rdWord,
    input  wire logic                rdHit
);

    logic              awHeld_q, awHeld_d;
    logic              wHeld_q,  wHeld_d;
    logic              bValid_q, bValid_d;
    logic              rValid_q, rValid_d;
    logic              awReady_q;
    logic              wReady_q;
    logic              arReady_q;
    logic [CSM_AW-1:0] awAddr_q;
    logic [CSM_DW-1:0] wData_q;
    logic [3:0]        wStrb_q;
    logic [1:0]        bResp_q;
    logic [1:0]        rResp_q;
    logic [CSM_DW-1:0] rData_q;

    wire awTake = axiReq.awvalid & awReady_q;
    wire wTake  = axiReq.wvalid & wReady_q;
    wire arTake = axiReq.arvalid & arReady_q;
    wire bDone  = bValid_q & axiReq.bready;
    wire rDone  = rValid_q & axiReq.rready;

    // Address and data may arrive in either order; fire once both held
    assign wrFire = awHeld_q & wHeld_q & ~bValid_q;
    assign wrAddr = awAddr_q;
    assign wrData = wData_q;
    assign wrStrb = wStrb_q;
    assign rdAddr = axiReq.araddr;

    assign awHeld_d = awTake ? 1'b1 : (wrFire ? 1'b0 : awHeld_q);
    assign wHeld_d  = wTake  ? 1'b1 : (wrFire ? 1'b0 : wHeld_q);
    assign bValid_d = wrFire ? 1'b1 : (bDone  ? 1'b0 : bValid_q);
    assign rValid_d = arTake ? 1'b1 : (rDone  ? 1'b0 : rValid_q);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            bValid_q  <= 1'b0;
            rValid_q  <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q  <= 1'b0;
            arReady_q <= 1'b0;
        end else begin
            awHeld_q  <= awHeld_d;
            wHeld_q   <= wHeld_d;
            bValid_q  <= bValid_d;
            rValid_q  <= rValid_d;
            // Readies are flops so the top presents registered outputs
            awReady_q <= ~awHeld_d & ~bValid_d;
            wReady_q  <= ~wHeld_d & ~bValid_d;
            arReady_q <= ~rValid_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awAddr_q <= '0;
            wData_q  <= '0;
            wStrb_q  <= '0;
            bResp_q  <= RESP_OKAY;
            rResp_q  <= RESP_OKAY;
            rData_q  <= '0;
        end else begin
            if (awTake) begin
                awAddr_q <= axiReq.awaddr;
            end
            if (wTake) begin
                wData_q <= axiReq.wdata;
                wStrb_q <= axiReq.wstrb;
            end
            if (wrFire) begin
                bResp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (arTake) begin
                rData_q <= rdHit ? rdWord : '0;
                rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign axiRsp.awready = awReady_q;
    assign axiRsp.wready  = wReady_q;
    assign axiRsp.bvalid  = bValid_q;
    assign axiRsp.bresp   = bResp_q;
    assign axiRsp.arready = arReady_q;
    assign axiRsp.rvalid  = rValid_q;
    assign axiRsp.rdata   = rData_q;
    assign axiRsp.rresp   = rResp_q;

endmodule

// [rtl/csm_status_reg.sv]
// Processor status and mode register with mode and interrupt decode
//
// Functional notes
// - Usable bits grant coprocessors; zero is always usable in kernel mode
// - Register count select gives 16 registers at 0, 32 at 1
// - Reverse byte order acts only in user mode
// - Boot vector select picks normal or bootstrap exception vectors
// - Warm reset indicator reads 1 after soft reset or NMI
// - Probe hit flag records hit or miss of last hit-type cache op
// - Check-bit override makes cache check bits come from ECC register
// - Parity exception disable stops cache parity errors raising exceptions
// - Reserved bits written as zero by software, always read zero
// - Interrupt taken when enabled and same mask and pending bit set
// - Kernel extended vector select picks ordinary or extended refill
// - Supervisor wide addressing selects 64-bit ops and extended refill
// - User wide addressing selects 64-bit operation and extended refill
// - Mode decode: user 10, supervisor 01, else kernel or levels set
// - Interrupts enabled only with enable set and both levels clear
// - A newly set interrupt enable may take up to 3 cycles
// - User and supervisor width independent; kernel always 64-bit
// - 64-bit opcodes always valid in kernel mode
// - Reset forces error level and boot vector select to 1
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module csm_status_reg import csm_pkg::*; #(
    parameter int EN_DELAY = IRQ_EN_SET_DELAY
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire csm_axil_req_t axiReq,
    output csm_axil_rsp_t      axiRsp,
    input  wire logic [7:0]    irqPending,
    input  wire logic          softResetEvt,
    input  wire logic          probeValid,
    input  wire logic          probeHit,
    output csm_mode_t          mode,
    output logic               irqEnabled,
    output logic               irqTake,
    output logic [3:0]         cpUsable,
    output logic               fpuRegs32,
    output logic               byteOrderFlip,
    output logic               bootVectors,
    output logic               kernelExtRefill,
    output logic               superExtRefill,
    output logic               userExtRefill,
    output logic               wideAddrActive,
    output logic               op64Valid,
    output logic               checkBitOverride,
    output logic               parityExcDisable,
    output logic [31:0]        statusWord
);

    function automatic logic regHit(input logic [CSM_AW-1:0] addr);
        return (addr == STATUS_OFS) || (addr == VIEW_OFS);
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                               input logic [31:0] newW,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = oldW;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = newW[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Bus side
    logic              wrFire;
    logic [CSM_AW-1:0] wrAddr;
    logic [CSM_DW-1:0] wrData;
    logic [3:0]        wrStrb;
    logic [CSM_AW-1:0] rdAddr;
    logic [CSM_DW-1:0] rdWord;

    csm_axil_port u_port (
        .sys_clk (sys_clk),
        .reset   (reset),
        .axiReq  (axiReq),
        .axiRsp  (axiRsp),
        .wrFire  (wrFire),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrHit   (regHit(wrAddr)),
        .rdAddr  (rdAddr),
        .rdWord  (rdWord),
        .rdHit   (regHit(rdAddr))
    );

    // Status register state
    csm_status_t             status_q, status_d;
    logic [EN_DELAY-2:0]     enAge_q;
    csm_view_t               view;

    wire statusWrite = wrFire && (wrAddr == STATUS_OFS);
    // Reserved positions masked on the software write path; hardware events set only writable bits
    wire [31:0] writeWord =
        mergeBytes(status_q, wrData, wrStrb) & STATUS_WMASK;

    always_comb begin
        status_d = statusWrite ? csm_status_t'(writeWord) : status_q;
        // Hardware events win over a software write in the same cycle
        if (softResetEvt) begin
            status_d.warmResetIndicator = 1'b1;
            status_d.errorLevelFlag     = 1'b1;
            status_d.bootVectorSelect   = 1'b1;
        end
        if (probeValid) begin
            status_d.lastProbeHitFlag = probeHit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_q <= csm_status_t'(STATUS_RESET);
        end else begin
            status_q <= status_d;
        end
    end

    // Age of a set enable; a fresh set waits, a clear acts at once
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enAge_q <= '0;
        end else begin
            // Oldest sample falls off the top of the chain
            enAge_q <= (EN_DELAY-1)'({enAge_q,
                                      status_q.globalIrqEnable});
        end
    end

    // Mode decode
    wire levelSet = status_q.exceptionLevelFlag | status_q.errorLevelFlag;
    wire userNow  = (status_q.privilegeModeField == PRIV_USER) &
                    ~levelSet;
    wire superNow = (status_q.privilegeModeField == PRIV_SUPER) &
                    ~levelSet;
    // Field code 11 also decodes as kernel: the safe fallback
    wire kernelNow = ~userNow & ~superNow;

    wire csm_mode_t modeD = userNow  ? MODE_USER :
                            superNow ? MODE_SUPER : MODE_KERNEL;

    wire irqLive = status_q.globalIrqEnable & enAge_q[EN_DELAY-2] &
                   ~levelSet;
    // Bits 7..2 are hardware inputs 5..0, bits 1..0 software
    wire [7:0] pendMasked = irqPending &
                            status_q.interruptMaskBits;
    wire irqTakeD = irqLive & (|pendMasked);

    wire [3:0] cpUsableD = status_q.coprocUsableBits |
                           {3'h0, kernelNow};
    wire wideD = kernelNow |
                 (superNow & status_q.supervisorWideAddressing) |
                 (userNow & status_q.userWideAddressing);

    // Read view of the live decode
    assign view.rsv           = '0;
    assign view.pendingRaw    = irqPending;
    assign view.pendingMasked = pendMasked;
    assign view.cpUsable      = cpUsable;
    assign view.irqTake       = irqTake;
    assign view.irqEnabled    = irqEnabled;
    assign view.mode          = mode;

    assign rdWord = (rdAddr == VIEW_OFS) ? 32'(view) :
                    32'(status_q);

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode             <= MODE_KERNEL;
            irqEnabled       <= 1'b0;
            irqTake          <= 1'b0;
            // Reset decodes as kernel mode, so kernel grants hold
            cpUsable         <= 4'h1;
            fpuRegs32        <= 1'b0;
            byteOrderFlip    <= 1'b0;
            bootVectors      <= 1'b0;
            kernelExtRefill  <= 1'b0;
            superExtRefill   <= 1'b0;
            userExtRefill    <= 1'b0;
            wideAddrActive   <= 1'b1;
            op64Valid        <= 1'b1;
            checkBitOverride <= 1'b0;
            parityExcDisable <= 1'b0;
            statusWord       <= '0;
        end else begin
            mode             <= modeD;
            irqEnabled       <= irqLive;
            irqTake          <= irqTakeD;
            cpUsable         <= cpUsableD;
            fpuRegs32        <= status_q.fpuRegisterCountSelect;
            byteOrderFlip    <= userNow &
                                status_q.byteOrderFlipUser;
            bootVectors      <= status_q.bootVectorSelect;
            kernelExtRefill  <= status_q.kernelExtendedVectorSelect;
            superExtRefill   <= status_q.supervisorWideAddressing;
            userExtRefill    <= status_q.userWideAddressing;
            wideAddrActive   <= wideD;
            op64Valid        <= wideD | kernelNow;
            checkBitOverride <= status_q.checkBitOverride;
            parityExcDisable <= status_q.parityExceptionDisable;
            statusWord       <= 32'(status_q);
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence sEnHeld;
        (status_q.globalIrqEnable && !levelSet) [*3];
    endsequence

    sequence sUserDecode;
        status_q.privilegeModeField == PRIV_USER && !levelSet;
    endsequence

    a_en_set_delay: assert property (
        ($rose(status_q.globalIrqEnable) && !irqEnabled) ##0 sEnHeld
        |=> irqEnabled)
        else $error("interrupt enable not effective after 3 cycles");

    a_en_not_early: assert property (
        ($rose(status_q.globalIrqEnable) && !irqEnabled) |=> !irqEnabled)
        else $error("interrupt enable took effect too early");

    a_irq_levels: assert property (
        $past(levelSet) |-> !irqEnabled)
        else $error("interrupts enabled with a level flag set");

    a_irq_take_cause: assert property (
        irqTake |-> $past(irqLive) && ($past(pendMasked) != 8'h00))
        else $error("interrupt taken without enable and masked pending");

    a_mode_user: assert property (
        sUserDecode |=> mode == MODE_USER)
        else $error("user mode not decoded");

    a_mode_kernel: assert property (
        (levelSet || status_q.privilegeModeField == PRIV_KERNEL)
        |=> mode == MODE_KERNEL)
        else $error("kernel mode not decoded");

    a_coproc_zero_kernel: assert property (
        mode == MODE_KERNEL |-> cpUsable[0])
        else $error("coprocessor zero unusable in kernel mode");

    a_flip_user_only: assert property (
        byteOrderFlip |-> mode == MODE_USER)
        else $error("byte order flipped outside user mode");

    a_resv_zero: assert property (
        (32'(status_q) & ~STATUS_WMASK) == 32'h0000_0000)
        else $error("reserved status bit not zero");

    a_warm_reset: assert property (
        softResetEvt |=> status_q.warmResetIndicator ##1
        statusWord[20])
        else $error("warm reset indicator not set");

    a_probe_hit: assert property (
        probeValid |=> status_q.lastProbeHitFlag == $past(probeHit))
        else $error("probe hit flag not recorded");

    a_reset_value: assert property (
        $past(reset) |-> status_q.errorLevelFlag &&
        status_q.bootVectorSelect)
        else $error("reset did not set error level and boot vector");

    a_op64_kernel: assert property (
        mode == MODE_KERNEL |-> op64Valid && wideAddrActive)
        else $error("64-bit operation refused in kernel mode");

    a_wide_user: assert property (
        mode == MODE_USER |->
        wideAddrActive == $past(status_q.userWideAddressing))
        else $error("user width does not follow its control");

    a_write_order: assert property (
        (statusWrite && !softResetEvt && !probeValid) |=>
        32'(status_q) == $past(writeWord))
        else $error("status write not applied on next edge");

endmodule

// [sim/tb_cpu_status_mode_register.sv]
// Self-checking bench for the processor status register block
`timescale 1ns/1ps
module tb_cpu_status_mode_register import csm_pkg::*;;

    logic          sys_clk      = 1'b0;
    logic          reset        = 1'b1;
    csm_axil_req_t req          = '0;
    csm_axil_rsp_t rsp;
    logic [7:0]    irqPending   = 8'h00;
    logic          softResetEvt = 1'b0;
    logic          probeValid   = 1'b0;
    logic          probeHit     = 1'b0;
    csm_mode_t     mode;
    logic          irqEnabled, irqTake, fpuRegs32, byteOrderFlip;
    logic          bootVectors, kernelExtRefill, superExtRefill;
    logic          userExtRefill, wideAddrActive, op64Valid;
    logic          checkBitOverride, parityExcDisable;
    logic [3:0]    cpUsable;
    logic [31:0]   statusWord;
    int            err_total    = 0;
    int            checks       = 0;
    int            cycles       = 0;

    csm_status_reg #(.EN_DELAY(IRQ_EN_SET_DELAY)) uut (
        .sys_clk(sys_clk), .reset(reset), .axiReq(req), .axiRsp(rsp),
        .irqPending(irqPending), .softResetEvt(softResetEvt),
        .probeValid(probeValid), .probeHit(probeHit), .mode(mode),
        .irqEnabled(irqEnabled), .irqTake(irqTake), .cpUsable(cpUsable),
        .fpuRegs32(fpuRegs32), .byteOrderFlip(byteOrderFlip),
        .bootVectors(bootVectors), .kernelExtRefill(kernelExtRefill),
        .superExtRefill(superExtRefill), .userExtRefill(userExtRefill),
        .wideAddrActive(wideAddrActive), .op64Valid(op64Valid),
        .checkBitOverride(checkBitOverride),
        .parityExcDisable(parityExcDisable), .statusWord(statusWord));

    always #2.5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Handshakes sampled at the falling edge, where registered
    // outputs are settled, and acted on at the next rising edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic awDone, wDone, awHit, wHit;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge sys_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(negedge sys_clk);
            awHit = req.awvalid && rsp.awready;
            wHit = req.wvalid && rsp.wready;
            @(posedge sys_clk);
            if (awHit) begin
                req.awvalid <= 1'b0;
                awDone = 1'b1;
            end
            if (wHit) begin
                req.wvalid <= 1'b0;
                wDone = 1'b1;
            end
        end
        req.bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            r = rsp.bresp;
            wHit = rsp.bvalid;
            @(posedge sys_clk);
        end while (wHit !== 1'b1);
        req.bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic arHit, rHit;
        @(posedge sys_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            arHit = req.arvalid && rsp.arready;
            rHit = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge sys_clk);
            if (arHit) begin
                req.arvalid <= 1'b0;
            end
        end while (rHit !== 1'b1);
        req.rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        logic [1:0] r;
        axi_write(a, d, s, r);
        chk_word({30'h0, r}, {30'h0, e});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] e);
        logic [1:0] r;
        axi_read(a, d, r);
        chk_word({30'h0, r}, {30'h0, e});
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_word(d, STATUS_RESET);
        settle();
        chk_word(statusWord, STATUS_RESET);
        chk_bit(bootVectors, 1'b1);
        chk_word({30'h0, mode}, {30'h0, MODE_KERNEL});
    endtask

    task automatic t_fields();
        logic [31:0] d;
        wr(STATUS_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_word(d, STATUS_WMASK);
        settle();
        chk_word(statusWord, STATUS_WMASK);
        chk_word({28'h0, cpUsable}, 32'h0000_000f);
        chk_bit(fpuRegs32, 1'b1);
        chk_bit(checkBitOverride, 1'b1);
        chk_bit(parityExcDisable, 1'b1);
        chk_bit(kernelExtRefill, 1'b1);
        chk_bit(op64Valid, 1'b1);
        chk_bit(byteOrderFlip, 1'b0);
        chk_word({30'h0, mode}, {30'h0, MODE_KERNEL});
        // Only the low byte lane may change
        wr(STATUS_OFS, 32'h0000_0000, 4'h1, RESP_OKAY);
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_word(d, STATUS_WMASK & 32'hffff_ff00);
    endtask

    task automatic t_modes();
        logic [1:0] k;
        logic v, usr, sup, krn, wide;
        csm_mode_t em;
        for (int w = 0; w < 2; w++) begin
            for (int i = 0; i < 4; i++) begin
                for (int l = 0; l < 3; l++) begin
                    v = (w == 1);
                    k = 2'(i);
                    usr = (k == 2'h2) && (l == 0);
                    sup = (k == 2'h1) && (l == 0);
                    krn = !usr && !sup;
                    wide = krn || (usr && !v) || (sup && v);
                    em = usr ? MODE_USER : (sup ? MODE_SUPER : MODE_KERNEL);
                    wr(STATUS_OFS, {4'ha, 3'b001, 18'h0, v, !v, k,
                       l == 2, l == 1, 1'b0}, 4'hf, RESP_OKAY);
                    settle();
                    chk_word({30'h0, mode}, {30'h0, em});
                    chk_bit(byteOrderFlip, usr);
                    chk_word({28'h0, cpUsable}, {28'h0, 3'b101, krn});
                    chk_bit(wideAddrActive, wide);
                    chk_bit(op64Valid, wide);
                    chk_bit(superExtRefill, v);
                    chk_bit(userExtRefill, !v);
                    chk_bit(kernelExtRefill, 1'b0);
                    chk_bit(bootVectors, 1'b0);
                    chk_bit(fpuRegs32, 1'b0);
                end
            end
        end
    endtask

    task automatic t_irq();
        logic [7:0] m;
        logic [31:0] d;
        logic [7:0] lows [4] = '{8'h00, 8'h02, 8'h03, 8'h05};
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wr(STATUS_OFS, {16'h0, m, 8'h01}, 4'hf, RESP_OKAY);
            irqPending <= m;
            // Write landed an edge before wr returns: three edges in all
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk_bit(irqEnabled, 1'b1);
            chk_bit(irqTake, 1'b1);
            rd(VIEW_OFS, d, RESP_OKAY);
            chk_word(d, {8'h00, m, m, 8'h1c});
            @(posedge sys_clk);
            irqPending <= ~m;
            settle();
            chk_bit(irqTake, 1'b0);
        end
        irqPending <= m;
        // Enable cleared before exception level rises, then error level
        for (int j = 0; j < 4; j++) begin
            wr(STATUS_OFS, {16'h0, m, lows[j]}, 4'hf, RESP_OKAY);
            settle();
            chk_bit(irqEnabled, 1'b0);
            chk_bit(irqTake, 1'b0);
        end
    endtask

    task automatic t_events();
        logic [31:0] d;
        wr(STATUS_OFS, 32'h0000_0000, 4'hf, RESP_OKAY);
        softResetEvt <= 1'b1;
        @(posedge sys_clk);
        softResetEvt <= 1'b0;
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_bit(d[20], 1'b1);
        probeValid <= 1'b1;
        probeHit <= 1'b1;
        @(posedge sys_clk);
        probeValid <= 1'b0;
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_bit(d[18], 1'b1);
        probeValid <= 1'b1;
        probeHit <= 1'b0;
        @(posedge sys_clk);
        probeValid <= 1'b0;
        // Hit level without a completed op must not be recorded
        probeHit <= 1'b1;
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_bit(d[18], 1'b0);
    endtask

    task automatic t_errors();
        logic [31:0] d;
        wr(STATUS_OFS, 32'h1000_0000, 4'hf, RESP_OKAY);
        wr(8'h08, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd(8'h08, d, RESP_SLVERR);
        chk_word(d, 32'h0000_0000);
        wr(VIEW_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(STATUS_OFS, d, RESP_OKAY);
        chk_word(d, 32'h1000_0000);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_fields();
        t_modes();
        t_irq();
        t_events();
        t_errors();
        end_of_test();
    end

endmodule
